// File: rtl/dram_host_ctrl.sv
`timescale 1ns/100ps
`include "dram_host_defines.svh"

module dram_host_ctrl
   import dram_host_pkg::*;
#(
   parameter int ADDR_W   = 9,
   parameter int DATA_W   = 32,
   parameter int LANES    = 4,
   parameter int RS_W     = 3,
   parameter int TIMER_W  = 12,
   parameter int INIT_CYC = `INIT_CYC,
   parameter int REF_CYC  = `REF_CYC,
   parameter int RASC_CYC = `RASC_CYC
) (
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic                  refresh_use_cbr,
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire logic                  req_write,
   input  wire logic [2*ADDR_W-1:0]   req_addr,
   input  wire logic [LANES-1:0]      req_be,
   input  wire logic [DATA_W-1:0]     req_wdata,
   output logic                       resp_valid,
   output logic      [DATA_W-1:0]     resp_rdata,
   output logic                       init_done,
   output logic      [RS_W-1:0]       row_strobe_n,
   output logic      [LANES-1:0]      column_strobe_n,
   output logic                       write_enable_n,
   output logic      [ADDR_W-1:0]     mux_address,
   input  wire logic [DATA_W-1:0]     data_bus_in,
   output logic      [DATA_W-1:0]     data_bus_out,
   output logic      [DATA_W-1:0]     data_bus_oe
);

   // ------------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------------
   ctrl_state_type       state_r;
   ctrl_state_type       state_nxt;
   logic [2:0]           cnt_r;
   logic [2:0]           cnt_nxt;
   logic [3:0]           init_left_r;
   logic                 ref_pending_r;
   logic                 ref_pending_nxt;
   logic [ADDR_W-1:0]    ref_row_r;
   logic [ADDR_W-1:0]    cur_row_r;
   logic [ADDR_W-1:0]    col_r;
   logic [LANES-1:0]     be_r;
   logic                 write_r;
   logic                 ras_low_r;
   logic                 ras_low_nxt;
   logic [LANES-1:0]     cas_n_r;
   logic [LANES-1:0]     cas_n_nxt;
   logic                 we_n_r;
   logic                 we_low_nxt;
   logic [ADDR_W-1:0]    addr_r;
   logic [ADDR_W-1:0]    addr_nxt;
   logic                 oe_r;
   logic [DATA_W-1:0]    dout_r;
   logic [DATA_W-1:0]    rdata_r;
   logic                 resp_valid_r;

   logic [TIMER_W-1:0]   page_count;
   logic                 init_expired;
   logic                 ref_tick;
   logic                 rc_expired;
   logic                 rp_expired;
   logic                 ras_fall;
   logic                 ras_rise;
   logic                 timers_ok;
   logic                 start_ref;
   logic                 accept_idle;
   logic                 accept_page;
   logic                 page_hit;
   logic                 col_last;
   logic                 ror_last;
   logic                 cbr_ras_last;
   logic                 cbr_hold_last;
   logic                 sample_read;
   logic [ADDR_W-1:0]    req_row;
   logic [ADDR_W-1:0]    req_col;

   // ------------------------------------------------------------------------
   // interval timers
   // ------------------------------------------------------------------------
   // power-up pause, counted once after reset
   interval_timer #(.W(TIMER_W), .RESET_VAL(TIMER_W'(INIT_CYC - 1))) u_init_timer (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .load     (1'b0),
      .load_val ('0),
      .count    (),
      .expired  (init_expired)
   );

   // one refresh slot per row within the refresh period
   interval_timer #(.W(TIMER_W), .RESET_VAL(TIMER_W'(REF_CYC - 1))) u_ref_timer (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .load     (ref_tick),
      .load_val (TIMER_W'(REF_CYC - 1)),
      .count    (),
      .expired  (ref_tick)
   );

   // row cycle time from each row strobe fall
   interval_timer #(.W(TIMER_W), .RESET_VAL('0)) u_rc_timer (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .load     (ras_fall),
      .load_val (TIMER_W'(`RC_CYC - 1)),
      .count    (),
      .expired  (rc_expired)
   );

   // row precharge from each row strobe rise
   interval_timer #(.W(TIMER_W), .RESET_VAL('0)) u_rp_timer (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .load     (ras_rise),
      .load_val (TIMER_W'(`RP_CYC - 1)),
      .count    (),
      .expired  (rp_expired)
   );

   // longest row strobe low time in a page
   interval_timer #(.W(TIMER_W), .RESET_VAL('0)) u_page_timer (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .load     (ras_fall),
      .load_val (TIMER_W'(RASC_CYC - 1)),
      .count    (page_count),
      .expired  ()
   );

   // ------------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------------
   assign req_row       = req_addr[2*ADDR_W-1:ADDR_W];
   assign req_col       = req_addr[ADDR_W-1:0];
   assign ras_fall      = ras_low_nxt & ~ras_low_r;
   assign ras_rise      = ~ras_low_nxt & ras_low_r;
   assign timers_ok     = rc_expired & rp_expired;
   assign init_done     = (init_left_r == 4'h0) && (state_r != ST_POWERUP);
   assign col_last      = (cnt_r == 3'(`COL_CYC - 1));
   assign ror_last      = (cnt_r == 3'(`RAS_CYC - 1));
   assign cbr_ras_last  = (cnt_r == 3'(`CHR_CYC - 1));
   assign cbr_hold_last = (cnt_r == 3'(`CBR_HOLD_CYC - 1));
   assign start_ref     = (state_r == ST_IDLE) && timers_ok && (ref_pending_r || !init_done);
   assign accept_idle   = (state_r == ST_IDLE) && timers_ok && init_done && !ref_pending_r && req_valid;
   assign page_hit      = req_valid && !ref_pending_r && (req_row == cur_row_r) && (req_write == write_r)
                          && (page_count > TIMER_W'(`PAGE_GUARD_CYC));
   assign accept_page   = (state_r == ST_COL) && col_last && page_hit;
   assign req_ready     = accept_idle || accept_page;
   assign sample_read   = (state_r == ST_COL) && col_last && !write_r;

   // refresh request stays pending until served; a new tick wins
   assign ref_pending_nxt = ref_tick | (ref_pending_r & ~start_ref);

   // ------------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_POWERUP:
            if (init_expired)
               state_nxt = ST_IDLE;
         ST_IDLE:
            if (start_ref)
               state_nxt = (init_done && refresh_use_cbr) ? ST_CBR_SETUP : ST_ROR;
            else if (accept_idle)
               state_nxt = ST_ROW;
         ST_ROW:
            state_nxt = ST_COL;
         ST_COL:
            if (col_last)
               state_nxt = accept_page ? ST_PAGE_PRE : ST_IDLE;
         ST_PAGE_PRE:
            state_nxt = ST_COL;
         ST_ROR:
            if (ror_last)
               state_nxt = ST_IDLE;
         ST_CBR_SETUP:
            state_nxt = ST_CBR_RAS;
         ST_CBR_RAS:
            if (cbr_ras_last)
               state_nxt = ST_CBR_HOLD;
         ST_CBR_HOLD:
            if (cbr_hold_last)
               state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   assign cnt_nxt = (state_nxt != state_r) ? 3'h0 : cnt_r + 3'h1;

   // ------------------------------------------------------------------------
   // pin values for the next cycle
   // ------------------------------------------------------------------------
   assign ras_low_nxt = (state_nxt == ST_ROW) || (state_nxt == ST_COL) || (state_nxt == ST_PAGE_PRE)
                        || (state_nxt == ST_ROR) || (state_nxt == ST_CBR_RAS) || (state_nxt == ST_CBR_HOLD);

   assign cas_n_nxt = (state_nxt == ST_COL) ? ~be_r :
                      ((state_nxt == ST_CBR_SETUP) || (state_nxt == ST_CBR_RAS)) ? '0 :
                      '1;

   assign addr_nxt = (state_nxt == ST_ROW) ? req_row :
                     (state_nxt == ST_COL) ? col_r :
                     (state_nxt == ST_ROR) ? ref_row_r :
                     addr_r;

   // write enable low from row strobe, ahead of column fall; high for reads
   assign we_low_nxt = ((state_nxt == ST_ROW) && req_write)
                       || (((state_nxt == ST_COL) || (state_nxt == ST_PAGE_PRE)) && write_r);

   // ------------------------------------------------------------------------
   // state and counters
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state_r       <= ST_POWERUP;
         cnt_r         <= 3'h0;
         ref_pending_r <= 1'b0;
      end
      else
      begin
         state_r       <= state_nxt;
         cnt_r         <= cnt_nxt;
         ref_pending_r <= ref_pending_nxt;
      end
   end

   // eight row-only cycles before first access, row counter for refresh
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         init_left_r <= 4'(`INIT_REF_CYCLES);
         ref_row_r   <= '0;
      end
      else if ((state_r == ST_ROR) && ror_last)
      begin
         if (init_left_r != 4'h0)
            init_left_r <= init_left_r - 4'h1;
         ref_row_r <= ref_row_r + ADDR_W'(1);
      end
   end

   // ------------------------------------------------------------------------
   // request capture
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cur_row_r <= '0;
         col_r     <= '0;
         be_r      <= '0;
         write_r   <= 1'b0;
         dout_r    <= '0;
      end
      else if (req_ready)
      begin
         cur_row_r <= req_row;
         col_r     <= req_col;
         be_r      <= req_be;
         write_r   <= req_write;
         dout_r    <= req_wdata;
      end
   end

   // ------------------------------------------------------------------------
   // pin registers
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ras_low_r <= 1'b0;
         cas_n_r   <= '1;
         we_n_r    <= 1'b1;
         addr_r    <= '0;
         oe_r      <= 1'b0;
      end
      else
      begin
         ras_low_r <= ras_low_nxt;
         cas_n_r   <= cas_n_nxt;
         we_n_r    <= ~we_low_nxt;
         addr_r    <= addr_nxt;
         // drive only on writes; reads release through precharge first
         oe_r      <= we_low_nxt;
      end
   end

   // ------------------------------------------------------------------------
   // read return
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rdata_r      <= '0;
         resp_valid_r <= 1'b0;
      end
      else
      begin
         resp_valid_r <= sample_read;
         if (sample_read)
            rdata_r <= data_bus_in;
      end
   end

   // ------------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------------
   assign row_strobe_n    = {RS_W{~ras_low_r}};
   assign column_strobe_n = cas_n_r;
   assign write_enable_n  = we_n_r;
   assign mux_address     = addr_r;
   assign data_bus_out    = dout_r;
   assign data_bus_oe     = {DATA_W{oe_r}};
   assign resp_valid      = resp_valid_r;
   assign resp_rdata      = rdata_r;

endmodule // dram_host_ctrl

// File: rtl/dram_host_defines.svh
`ifndef DRAM_HOST_DEFINES_SVH
`define DRAM_HOST_DEFINES_SVH

// ----------------------------------------------------------------------------
// clock and rounding
// ----------------------------------------------------------------------------
`define CLK_NS              50
`define CEIL_CYC(ns)        ((((ns) + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : (((ns) + `CLK_NS - 1) / `CLK_NS))
`define FLOOR_CYC(ns)       (((ns) / `CLK_NS) < 1 ? 1 : ((ns) / `CLK_NS))

// ----------------------------------------------------------------------------
// power-up and refresh
// ----------------------------------------------------------------------------
`define T_INIT_NS           100000
`define INIT_REF_CYCLES     8
`define T_REFRESH_PERIOD_NS 8000000
`define REF_ROWS            512
`define INIT_CYC            `CEIL_CYC(`T_INIT_NS)
`define REF_CYC             `FLOOR_CYC(`T_REFRESH_PERIOD_NS / `REF_ROWS)

// ----------------------------------------------------------------------------
// strobe timing, fastest grade
// ----------------------------------------------------------------------------
`define T_RC_NS             125
`define T_RP_NS             55
`define T_RAS_NS            60
`define T_CAS_NS            20
`define T_CSR_NS            10
`define T_CHR_NS            15
`define T_RPC_NS            10
`define T_PC_NS             45
`define T_CP_NS             10
`define T_PAGE_ROW_STROBE_WIDTH_NS 100000
`define T_AA_NS             30
`define T_CAC_NS            20
`define T_ACP_NS            40
`define T_OFF_NS            20
`define T_ROW_TO_COL_STROBE_DELAY_MAX_NS 40
`define T_ROW_TO_COL_ADDR_DELAY_MAX_NS   30

`define RC_CYC              `CEIL_CYC(`T_RC_NS)
`define RP_CYC              `CEIL_CYC(`T_RP_NS)
`define RAS_CYC             `CEIL_CYC(`T_RAS_NS)
`define CSR_CYC             `CEIL_CYC(`T_CSR_NS)
`define CHR_CYC             `CEIL_CYC(`T_CHR_NS)
`define RASC_CYC            `FLOOR_CYC(`T_PAGE_ROW_STROBE_WIDTH_NS)
`define PAGE_GUARD_CYC      4
`define ACC_NS              ((`T_ACP_NS > `T_AA_NS) ? ((`T_ACP_NS > `T_CAC_NS) ? `T_ACP_NS : `T_CAC_NS) : \
                             ((`T_AA_NS > `T_CAC_NS) ? `T_AA_NS : `T_CAC_NS))
`define COL_CYC             ((`CEIL_CYC(`ACC_NS) > `CEIL_CYC(`T_CAS_NS)) ? `CEIL_CYC(`ACC_NS) : `CEIL_CYC(`T_CAS_NS))
`define CBR_HOLD_CYC        ((`RAS_CYC > `CHR_CYC) ? (`RAS_CYC - `CHR_CYC) : 1)

`endif

// File: rtl/dram_host_pkg.sv
package dram_host_pkg;

   typedef enum logic [3:0] {
      ST_POWERUP,
      ST_IDLE,
      ST_ROW,
      ST_COL,
      ST_PAGE_PRE,
      ST_ROR,
      ST_CBR_SETUP,
      ST_CBR_RAS,
      ST_CBR_HOLD
   } ctrl_state_type;

endpackage

// File: rtl/interval_timer.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// down counter, reload on demand
// ----------------------------------------------------------------------------
module interval_timer #(
   parameter int              W         = 12,
   parameter logic [W-1:0]    RESET_VAL = '0
) (
   input  wire logic          clk_sys,
   input  wire logic          sys_rst,
   input  wire logic          load,
   input  wire logic [W-1:0]  load_val,
   output logic      [W-1:0]  count,
   output logic               expired
);

   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   assign expired   = (count_r == '0);
   assign count_nxt = load ? load_val : (expired ? count_r : count_r - W'(1));
   assign count     = count_r;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         count_r <= RESET_VAL;
      else
         count_r <= count_nxt;
   end

endmodule // interval_timer

// File: bench/dram_module_model.sv
`timescale 1ns/100ps
module dram_module_model (
   input  wire logic        clk_sys,
   input  wire logic [2:0]  row_strobe_n,
   input  wire logic [3:0]  column_strobe_n,
   input  wire logic        write_enable_n,
   input  wire logic [8:0]  mux_address,
   input  wire logic [31:0] dq_in,
   output logic      [31:0] dq_out
);
   logic [31:0] mem [logic [17:0]];
   logic [8:0]  row_r = '0;
   logic [8:0]  refresh_row_r = '0;
   logic        row_prev_r = 1'b1;
   logic [3:0]  col_prev_r = 4'hf;
   logic [31:0] last_r = '0;
   logic [31:0] word;

   // ------
   // strobe edges seen at the clock
   // ------
   always @(posedge clk_sys)
   begin
      row_prev_r <= row_strobe_n[0];
      col_prev_r <= column_strobe_n;
      last_r     <= dq_out;
      if (row_prev_r && !row_strobe_n[0] && column_strobe_n == 4'hf)
         row_r <= mux_address;
      if (row_prev_r && !row_strobe_n[0] && column_strobe_n == 4'h0)
         refresh_row_r <= refresh_row_r + 9'h1;
      for (int i = 0; i < 4; i++)
         if (!row_strobe_n[0] && !write_enable_n && col_prev_r[i] && !column_strobe_n[i])
         begin
            if (!mem.exists({row_r, mux_address}))
               mem[{row_r, mux_address}] = '0;
            mem[{row_r, mux_address}][8*i +: 8] = dq_in[8*i +: 8];
         end
   end

   // ------
   // read drive, released lanes toggle
   // ------
   always @*
   begin
      word = mem.exists({row_r, mux_address}) ? mem[{row_r, mux_address}] : 32'h0;
      for (int i = 0; i < 4; i++)
         dq_out[8*i +: 8] = (!row_strobe_n[0] && write_enable_n && !column_strobe_n[i])
                            ? word[8*i +: 8] : ~last_r[8*i +: 8];
   end
endmodule // dram_module_model

// File: bench/dram_host_ctrl_asserts.sv
`timescale 1ns/100ps
module dram_host_ctrl_asserts #(
   parameter int INIT_CYC = 2000,
   parameter int REF_CYC  = 312,
   parameter int RASC_CYC = 2000
) (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [17:0] req_addr,
   input wire logic [3:0]  req_be,
   input wire logic        init_done,
   input wire logic [2:0]  row_strobe_n,
   input wire logic [3:0]  column_strobe_n,
   input wire logic        write_enable_n,
   input wire logic [8:0]  mux_address,
   input wire logic [31:0] data_bus_out,
   input wire logic [31:0] data_bus_oe
);
   logic [15:0] up_cnt_r;
   logic [3:0]  fall_cnt_r;
   logic [15:0] low_cnt_r;
   logic [15:0] gap_cnt_r;
   logic        row_q_r;
   logic [3:0]  col_q_r;
   wire         row_low = !row_strobe_n[0];
   wire         ref_mark = (row_low && !row_q_r && column_strobe_n == 4'hf && col_q_r == 4'hf)
                           || (!row_low && column_strobe_n == 4'h0);

   always_ff @(posedge clk_sys)
   begin
      row_q_r <= row_strobe_n[0];
      col_q_r <= column_strobe_n;
      if (sys_rst)
      begin
         up_cnt_r   <= '0;
         fall_cnt_r <= '0;
         low_cnt_r  <= '0;
         gap_cnt_r  <= '0;
      end
      else
      begin
         up_cnt_r   <= (up_cnt_r == 16'hffff) ? up_cnt_r : up_cnt_r + 16'h1;
         fall_cnt_r <= (row_q_r && row_low && fall_cnt_r != 4'hf) ? fall_cnt_r + 4'h1 : fall_cnt_r;
         low_cnt_r  <= row_low ? low_cnt_r + 16'h1 : 16'h0;
         gap_cnt_r  <= (ref_mark || !init_done) ? 16'h0 : gap_cnt_r + 16'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_init_no_req: assert property (!init_done |-> !req_ready) else $error("request taken in init");
   a_init_pause: assert property (up_cnt_r < INIT_CYC - 1 |-> row_strobe_n == 3'h7)
      else $error("strobe in power-up pause");
   a_init_cycles: assert property ($rose(init_done) |-> fall_cnt_r >= 4'h8) else $error("few init cycles");
   a_refresh_gap: assert property (gap_cnt_r <= REF_CYC + RASC_CYC + 8) else $error("refresh late");
   a_cbr_order: assert property ((row_strobe_n[0] && column_strobe_n == 4'h0) |=>
      (row_low && column_strobe_n == 4'h0) ##1 (row_low && column_strobe_n == 4'hf)) else $error("cbr order");
   a_cbr_recovery: assert property (($fell(column_strobe_n[0]) && row_strobe_n[0]) |-> $past(row_strobe_n[0]))
      else $error("cbr recovery");
   a_early_write: assert property ($fell(write_enable_n) |-> column_strobe_n == 4'hf) else $error("late write");
   a_write_data: assert property ((!write_enable_n && column_strobe_n != 4'hf && $past(column_strobe_n) == 4'hf)
      |-> (data_bus_oe == 32'hffffffff && $stable(data_bus_out))) else $error("write data");
   a_read_we_high: assert property ((row_low && column_strobe_n != 4'hf && write_enable_n) |=>
      (write_enable_n || column_strobe_n == 4'hf)) else $error("we in read");
   a_cycle_spacing: assert property ($fell(row_strobe_n[0]) |=> row_low ##1 !$fell(row_strobe_n[0]))
      else $error("cycle spacing");
   a_row_precharge: assert property ($rose(row_strobe_n[0]) |=> row_strobe_n[0]) else $error("precharge");
   a_page_cycle: assert property ((req_valid && req_ready && row_low) |=> (row_low && column_strobe_n == 4'hf)
      ##1 (row_low && column_strobe_n == ~$past(req_be, 2))) else $error("page cycle");
   a_page_limit: assert property (low_cnt_r <= RASC_CYC) else $error("page too long");
   a_row_addr: assert property ((req_valid && req_ready && !row_low) |=> (row_low && mux_address ==
      $past(req_addr[17:9])) ##1 (mux_address == $past(req_addr[8:0], 2) && column_strobe_n == ~$past(req_be, 2)))
      else $error("address order");
endmodule // dram_host_ctrl_asserts

bind dram_host_ctrl dram_host_ctrl_asserts #(.INIT_CYC(INIT_CYC), .REF_CYC(REF_CYC), .RASC_CYC(RASC_CYC)) u_asserts (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
   .req_be(req_be), .init_done(init_done), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
   .write_enable_n(write_enable_n), .mux_address(mux_address), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));

// File: bench/dram_host_ctrl_tb.sv
`timescale 1ns/100ps
module dram_host_ctrl_tb;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        refresh_use_cbr = 1'b0;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic [17:0] req_addr = '0;
   logic [3:0]  req_be = '0;
   logic [31:0] req_wdata = '0;
   logic        req_ready, resp_valid, init_done, write_enable_n;
   logic [31:0] resp_rdata, data_bus_in, data_bus_out, data_bus_oe, model_dq;
   logic [2:0]  row_strobe_n;
   logic [3:0]  column_strobe_n;
   logic [8:0]  mux_address;
   int          miscompares = 0;
   int          n_checks = 0;
   int          seed = 15659;
   int          k;
   logic [8:0]  cbr_base;
   logic [31:0] shadow [logic [17:0]];
   logic [31:0] exp_q [$];
   logic [17:0] adr [8];

   always #25 clk_sys = ~clk_sys;
   assign data_bus_in = (data_bus_oe & data_bus_out) | (~data_bus_oe & model_dq);

   dram_host_ctrl #(.INIT_CYC(10), .REF_CYC(40), .RASC_CYC(20)) u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .refresh_use_cbr(refresh_use_cbr), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
      .resp_valid(resp_valid), .resp_rdata(resp_rdata), .init_done(init_done), .row_strobe_n(row_strobe_n),
      .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n), .mux_address(mux_address),
      .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));

   dram_module_model u_model (
      .clk_sys(clk_sys), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
      .write_enable_n(write_enable_n), .mux_address(mux_address), .dq_in(data_bus_in), .dq_out(model_dq));

   // ------
   // shared tasks
   // ------
   task automatic check(input logic [31:0] seen, input logic [31:0] expct);
      n_checks++;
      if (seen !== expct)
      begin
         miscompares++;
         $display("Error at %0t: saw %h want %h", $time, seen, expct);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic hang;
      miscompares++;
      $display("Error at %0t: wait ran out", $time);
      results;
   endtask

   task automatic req(input logic w, input logic [17:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_write = w;
      req_addr  = a;
      req_be    = be;
      req_wdata = d;
      #1;
      for (int i = 0; i < 400 && req_ready !== 1'b1; i++)
      begin
         @(negedge clk_sys);
         #1;
      end
      if (req_ready !== 1'b1)
         hang;
      else
      begin
         if (!shadow.exists(a))
            shadow[a] = 32'h0;
         if (w)
            shadow[a] = (shadow[a] & ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}})
                        | (d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
         else
            exp_q.push_back(shadow[a]);
         @(posedge clk_sys);
      end
   endtask

   task automatic drain;
      @(negedge clk_sys);
      req_valid = 1'b0;
      for (int i = 0; i < 50 && exp_q.size() > 0; i++)
         @(negedge clk_sys);
      if (exp_q.size() > 0)
         hang;
   endtask

   task automatic wait_init;
      for (int i = 0; i < 300 && init_done !== 1'b1; i++)
         @(negedge clk_sys);
      if (init_done !== 1'b1)
         hang;
   endtask

   // ------
   // read results against the queue
   // ------
   always @(negedge clk_sys)
      if (resp_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(32'h1, 32'h0);
         else
         begin
            check(resp_rdata, exp_q[0]);
            void'(exp_q.pop_front());
         end
      end

   initial
   begin
      repeat (8) @(negedge clk_sys);
      check({row_strobe_n, column_strobe_n, write_enable_n, req_ready, init_done, 22'h0}, {3'h7, 4'hf, 3'h4, 22'h0});
      check(data_bus_oe, 32'h0);
      sys_rst = 1'b0;
      wait_init;
      $display("test reset done");
      for (k = 0; k < 8; k++)
      begin
         adr[k] = 18'($random(seed));
         req(1'b1, adr[k], 4'hf, $random(seed));
         req(1'b1, adr[k], 4'h1 << (k % 4), $random(seed));
         req(1'b0, adr[k], 4'hf, 32'h0);
      end
      drain;
      $display("test random access done");
      for (k = 0; k < 12; k++)
         req(1'b1, {9'h1ff, 9'(k * 46)}, 4'hf, $random(seed));
      for (k = 0; k < 12; k++)
         req(1'b0, {9'h1ff, 9'(k * 46)}, 4'hf, 32'h0);
      drain;
      $display("test page done");
      refresh_use_cbr = 1'b1;
      cbr_base = u_model.refresh_row_r;
      repeat (150) @(negedge clk_sys);
      check({31'h0, (u_model.refresh_row_r - cbr_base) >= 9'h3}, 32'h1);
      for (k = 0; k < 8; k++)
         req(1'b0, adr[k], 4'hf, 32'h0);
      drain;
      refresh_use_cbr = 1'b0;
      $display("test refresh done");
      sys_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      check({row_strobe_n, column_strobe_n, write_enable_n, req_ready, init_done, 22'h0}, {3'h7, 4'hf, 3'h4, 22'h0});
      sys_rst = 1'b0;
      wait_init;
      for (k = 0; k < 4; k++)
         req(1'b0, adr[k], 4'hf, 32'h0);
      drain;
      $display("test second reset done");
      results;
   end
endmodule // dram_host_ctrl_tb
